/* File: pkg/ptc_defines.svh */
/*
 * Register indices, field positions, reset values and widths of the PHY test
 * control and error counter bank.
 * Assumes it is included by bare name from design files that also use ptc_pkg.
 */
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH

// register indices; the byte address is four times the index
`define PTC_IDX_CTRL        8'h11
`define PTC_IDX_TEST        8'h12
`define PTC_IDX_FC          8'h13
`define PTC_IDX_DISC        8'h14
`define PTC_IDX_ERRF        8'h15
`define PTC_IDX_SYM         8'h16
`define PTC_IDX_EOF         8'h17
`define PTC_IDX_NONE        8'hff

// path_bypass_control fields
`define PTC_CTRL_RST        16'h0000
`define PTC_CTRL_WMASK      16'hfbbf
`define PTC_B_SCR_BYP       15
`define PTC_B_ENC_BYP       14
`define PTC_B_FRC_H         13
`define PTC_B_FRC_34        12
`define PTC_B_GOOD_LINK     11
`define PTC_B_MDI_TRI       9
`define PTC_B_DPD_DIS       8
`define PTC_B_AN_LPBK       7
`define PTC_B_FLT_BYP       5
`define PTC_B_APOL_DIS      4
`define PTC_B_SQT_DIS       3
`define PTC_B_EXT_SQ        2
`define PTC_B_LINK_DIS      1
`define PTC_B_JAB_DIS       0

// synth_test_and_probe fields
`define PTC_T_SHIFT         15
`define PTC_T_LOAD          14
`define PTC_T_BDT_EN        13
`define PTC_T_EQ_PROBE      12
`define PTC_T_10_PROBE      11
`define PTC_T_RST           3'h0
`define PTC_PHY_ADDR_RST    5'h01

// error counters
`define PTC_NUM_CNT         5
`define PTC_CNT_W           16
`define PTC_CNT_RST         16'h0000

`endif

/* File: pkg/ptc_pkg.sv */
/*
 * Types shared by the PHY test control and error counter bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ptc_pkg;

   typedef logic [15:0] ptc_half_t;
   typedef logic [7:0]  ptc_idx_t;
   typedef logic [4:0]  ptc_addr5_t;

   typedef enum logic [0:0] {
      PTC_ST_IDLE = 1'b0,
      PTC_ST_WAIT = 1'b1
   } ptc_bus_st_t;

endpackage : ptc_pkg

/* File: logic/ptc_sat_counter.sv */
/*
 * Saturating event counter with clear on read.
 * Assumes inc and clr are synchronous one-cycle strobes on hclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.svh"

module ptc_sat_counter #(
   parameter int W = `PTC_CNT_W
) (
   // clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // event and clear
   input  wire logic         inc,
   input  wire logic         clr,
   // count
   output var  logic [W-1:0] count
);
   import ptc_pkg::*;

   logic [W-1:0] count_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_reg <= '0;
      end else if (clr) begin
         count_reg <= inc ? W'(1) : '0;
      end else if (inc && count_reg != {W{1'b1}}) begin
         count_reg <= count_reg + W'(1);
      end
   end

   assign count = count_reg;

   a_cnt_saturate: assert property (@(posedge hclk) disable iff (!hresetn)
      (count_reg == {W{1'b1}} && !clr) |=> count_reg == {W{1'b1}})
      else $error("counter left full scale without a read");

   a_cnt_step: assert property (@(posedge hclk) disable iff (!hresetn)
      (inc && !clr && count_reg != {W{1'b1}}) |=> count_reg == $past(count_reg) + W'(1))
      else $error("counter did not step on an event");

   a_cnt_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      clr |=> count_reg == ($past(inc) ? W'(1) : W'(0)))
      else $error("counter clear lost or kept a coinciding event wrongly");

endmodule : ptc_sat_counter

`default_nettype wire

/* File: logic/ptc_one_shot.sv */
/*
 * One-cycle command pulses for the clock synthesizer.
 * Assumes trig is a one-cycle write strobe; more than one bit at once is refused.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.svh"

module ptc_one_shot #(
   parameter int W = 2
) (
   // clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // command request
   input  wire logic [W-1:0] trig,
   // pulses
   output var  logic [W-1:0] pulse
);
   import ptc_pkg::*;

   logic [W-1:0] pulse_reg;
   logic         single;

   // a request naming several commands at once is dropped
   assign single = (trig & (trig - W'(1))) == '0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_reg <= '0;
      end else begin
         pulse_reg <= single ? trig : '0;
      end
   end

   assign pulse = pulse_reg;

   a_pulse_single: assert property (@(posedge hclk) disable iff (!hresetn)
      (pulse_reg != '0) |-> ((pulse_reg & (pulse_reg - W'(1))) == '0) ##1 pulse_reg != $past(pulse_reg) || $past(trig) == $past(pulse_reg))
      else $error("synthesizer pulses overlap");

endmodule : ptc_one_shot

`default_nettype wire

/* File: logic/ptc_top.sv */
/*
 * PHY test control register, synthesizer test and probe register and five
 * saturating clear-on-read receive error counters, behind an AHB-Lite slave.
 * Assumes a single AHB-Lite master on hclk, single word transfers, and event
 * inputs that are one-cycle strobes synchronous to hclk.
 */
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.svh"

module ptc_top #(
   parameter ptc_pkg::ptc_addr5_t PHY_ADDR = `PTC_PHY_ADDR_RST
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   // receive error events
   input  wire logic        ev_false_carrier,
   input  wire logic        ev_disconnect,
   input  wire logic        ev_error_frame,
   input  wire logic        ev_symbol_error,
   input  wire logic        ev_early_eof,
   input  wire logic        repeater_mode,
   // signal detect and probe sources
   input  wire logic        signal_detect_raw,
   input  wire logic        eq_probe_in,
   input  wire logic [2:0]  tenbt_dig_in,
   input  wire logic        led_speed_norm,
   input  wire logic        led_link_norm,
   input  wire logic        led_act_norm,
   // transmit and receive path controls
   output var  logic        scrambler_bypass,
   output var  logic        encoder_bypass,
   output var  logic        force_h_pattern,
   output var  logic        force_34_pattern,
   output var  logic        adaptive_signal_detect,
   output var  logic        mdi_oe_n,
   output var  logic        dyn_pwrdn_disable,
   output var  logic        an_loopback,
   output var  logic        rx_filter_bypass,
   output var  logic        auto_polarity_disable,
   output var  logic        squelch_test_disable,
   output var  logic        ext_squelch,
   output var  logic        link_integrity_disable,
   output var  logic        jabber_disable,
   // synthesizer test
   output var  logic        synth_shift_pulse,
   output var  logic        synth_load_pulse,
   output var  logic        break_down_timer_en,
   // LEDs
   output var  logic        led_speed,
   output var  logic        led_link,
   output var  logic        led_act
);
   import ptc_pkg::*;

   localparam int NUM_CNT = `PTC_NUM_CNT;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave

   ptc_bus_st_t st_reg;
   ptc_bus_st_t st_next;
   ptc_idx_t    idx_reg;
   logic        wr_reg;
   logic        hreadyout_reg;
   logic [31:0] hrdata_reg;
   logic        addr_ph;
   logic        wr_stb;
   logic        rd_stb;
   ptc_half_t   rd_val;

   function automatic logic sel_hit(input ptc_idx_t cur, input ptc_idx_t want);
      return cur == want;
   endfunction : sel_hit

   assign addr_ph = hsel && htrans[1] && hready;
   assign wr_stb  = (st_reg == PTC_ST_WAIT) && wr_reg;
   assign rd_stb  = (st_reg == PTC_ST_WAIT) && !wr_reg;

   // every transfer gets one wait state, so reads never race a pending write
   always_comb begin
      case (st_reg)
         PTC_ST_IDLE: st_next = addr_ph ? PTC_ST_WAIT : PTC_ST_IDLE;
         PTC_ST_WAIT: st_next = PTC_ST_IDLE;
         default:     st_next = PTC_ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg        <= PTC_ST_IDLE;
         hreadyout_reg <= 1'b1;
      end else begin
         st_reg        <= st_next;
         hreadyout_reg <= (st_next != PTC_ST_WAIT);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idx_reg <= `PTC_IDX_NONE;
         wr_reg  <= 1'b0;
      end else if (addr_ph) begin
         idx_reg <= (haddr[31:10] == 22'h000000 && haddr[1:0] == 2'h0) ?
                    haddr[9:2] : `PTC_IDX_NONE;
         wr_reg  <= hwrite;
      end
   end

   assign hreadyout = hreadyout_reg;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // path_bypass_control

   ptc_half_t ctrl_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= `PTC_CTRL_RST;
      end else if (wr_stb && sel_hit(idx_reg, `PTC_IDX_CTRL)) begin
         ctrl_reg <= hwdata[15:0] & `PTC_CTRL_WMASK;
      end
   end

   assign scrambler_bypass       = ctrl_reg[`PTC_B_SCR_BYP];
   assign encoder_bypass         = ctrl_reg[`PTC_B_ENC_BYP];
   assign force_h_pattern        = ctrl_reg[`PTC_B_FRC_H];
   assign force_34_pattern       = ctrl_reg[`PTC_B_FRC_34];
   assign mdi_oe_n               = ctrl_reg[`PTC_B_MDI_TRI];
   assign dyn_pwrdn_disable      = ctrl_reg[`PTC_B_DPD_DIS];
   assign an_loopback            = ctrl_reg[`PTC_B_AN_LPBK];
   assign rx_filter_bypass       = ctrl_reg[`PTC_B_FLT_BYP];
   assign auto_polarity_disable  = ctrl_reg[`PTC_B_APOL_DIS];
   assign squelch_test_disable   = ctrl_reg[`PTC_B_SQT_DIS];
   assign ext_squelch            = ctrl_reg[`PTC_B_EXT_SQ];
   assign link_integrity_disable = ctrl_reg[`PTC_B_LINK_DIS];
   assign jabber_disable         = ctrl_reg[`PTC_B_JAB_DIS];

   logic asd_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         asd_reg <= 1'b0;
      end else begin
         asd_reg <= ctrl_reg[`PTC_B_GOOD_LINK] || signal_detect_raw;
      end
   end

   assign adaptive_signal_detect = asd_reg;

   ////////////////////////////////////////////////////////////////////////////
   // synth_test_and_probe

   logic [2:0] test_reg;
   logic [1:0] synth_trig;
   logic [1:0] synth_pulse;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         test_reg <= `PTC_T_RST;
      end else if (wr_stb && sel_hit(idx_reg, `PTC_IDX_TEST)) begin
         test_reg <= hwdata[`PTC_T_BDT_EN:`PTC_T_10_PROBE];
      end
   end

   assign synth_trig = (wr_stb && sel_hit(idx_reg, `PTC_IDX_TEST)) ?
                       hwdata[`PTC_T_SHIFT:`PTC_T_LOAD] : 2'h0;

   ptc_one_shot #(
      .W (2)
   ) u_one_shot (
      .hclk    (hclk),
      .hresetn (hresetn),
      .trig    (synth_trig),
      .pulse   (synth_pulse)
   );

   assign synth_shift_pulse   = synth_pulse[1];
   assign synth_load_pulse    = synth_pulse[0];
   assign break_down_timer_en = test_reg[2];

   logic led_speed_reg;
   logic led_link_reg;
   logic led_act_reg;

   // equalizer probe wins on speed LED
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         led_speed_reg <= 1'b0;
      end else if (test_reg[1]) begin
         led_speed_reg <= eq_probe_in;
      end else if (test_reg[0]) begin
         led_speed_reg <= tenbt_dig_in[0];
      end else begin
         led_speed_reg <= led_speed_norm;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         led_link_reg <= 1'b0;
         led_act_reg  <= 1'b0;
      end else begin
         led_link_reg <= test_reg[0] ? tenbt_dig_in[1] : led_link_norm;
         led_act_reg  <= test_reg[0] ? tenbt_dig_in[2] : led_act_norm;
      end
   end

   assign led_speed = led_speed_reg;
   assign led_link  = led_link_reg;
   assign led_act   = led_act_reg;

   ////////////////////////////////////////////////////////////////////////////
   // error counters

   logic [NUM_CNT-1:0] ev;
   logic [NUM_CNT-1:0] clr;
   ptc_half_t          cnt [NUM_CNT];

   // disconnects count only in repeater mode
   assign ev = {ev_early_eof, ev_symbol_error, ev_error_frame,
                ev_disconnect && repeater_mode, ev_false_carrier};

   generate
      for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
         assign clr[g] = rd_stb && sel_hit(idx_reg, ptc_idx_t'(`PTC_IDX_FC + g));
         ptc_sat_counter #(
            .W (`PTC_CNT_W)
         ) u_cnt (
            .hclk    (hclk),
            .hresetn (hresetn),
            .inc     (ev[g]),
            .clr     (clr[g]),
            .count   (cnt[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // read data

   always_comb begin
      case (idx_reg)
         `PTC_IDX_CTRL: rd_val = ctrl_reg;
         `PTC_IDX_TEST: rd_val = {2'h0, test_reg, 6'h00, PHY_ADDR};
         `PTC_IDX_FC:   rd_val = cnt[0];
         `PTC_IDX_DISC: rd_val = cnt[1];
         `PTC_IDX_ERRF: rd_val = cnt[2];
         `PTC_IDX_SYM:  rd_val = cnt[3];
         `PTC_IDX_EOF:  rd_val = cnt[4];
         default:       rd_val = 16'h0000;
      endcase
   end

   // value sampled at the clearing edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h00000000;
      end else if (rd_stb) begin
         hrdata_reg <= {16'h0000, rd_val};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_bus_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_ph |=> !hreadyout ##1 hreadyout)
      else $error("transfer did not take exactly one wait state");

   a_scram_bypass: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_stb && idx_reg == `PTC_IDX_CTRL) |=> scrambler_bypass == $past(hwdata[15]))
      else $error("scrambler bypass not taken from write");

   a_enc_h_34: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_stb && idx_reg == `PTC_IDX_CTRL) |=>
         {encoder_bypass, force_h_pattern, force_34_pattern} == $past(hwdata[14:12]))
      else $error("encoder or pattern force not taken from write");

   a_good_link: assert property (@(posedge hclk) disable iff (!hresetn)
      ctrl_reg[`PTC_B_GOOD_LINK] |=> adaptive_signal_detect)
      else $error("forced good link not shown on signal detect");

   a_mdi_tristate: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_stb && idx_reg == `PTC_IDX_CTRL) |=> mdi_oe_n == $past(hwdata[9]))
      else $error("media interface tristate not taken from write");

   a_jabber_link: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_stb && idx_reg == `PTC_IDX_CTRL) |=>
         {link_integrity_disable, jabber_disable} == $past(hwdata[1:0]))
      else $error("link integrity or jabber disable not taken from write");

   a_synth_excl: assert property (@(posedge hclk) disable iff (!hresetn)
      !(synth_shift_pulse && synth_load_pulse))
      else $error("shift and load pulses at once");

   a_synth_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (synth_shift_pulse || synth_load_pulse) |=> !(synth_shift_pulse || synth_load_pulse))
      else $error("synthesizer command pulse did not self-clear");

   a_eq_probe: assert property (@(posedge hclk) disable iff (!hresetn)
      test_reg[1] |=> led_speed == $past(eq_probe_in))
      else $error("equalizer probe not on speed LED");

   a_phy_addr: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_stb && idx_reg == `PTC_IDX_TEST) |=> hrdata[4:0] == PHY_ADDR)
      else $error("PHY address readback wrong");

   a_disc_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      (!repeater_mode && !clr[1]) |=> cnt[1] == $past(cnt[1]))
      else $error("disconnect counted outside repeater mode");

   a_read_value: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_stb && idx_reg == `PTC_IDX_FC) |=> hrdata[15:0] == $past(cnt[0]))
      else $error("counter read did not return value before clear");

endmodule : ptc_top

`default_nettype wire

/* File: sim/ptc_ahb_master.sv */
/*
 * Behavioural AHB-Lite master standing in for the management agent.
 * Assumes one slave whose hreadyout comes back as hready, single word transfers.
 */
`timescale 1ns/1ps
`default_nettype none

module ptc_ahb_master (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // commands from the bench
   input  wire logic        req,
   input  wire logic        req_write,
   input  wire logic [31:0] req_addr,
   input  wire logic [31:0] req_wdata,
   output var  logic        done,
   output var  logic        done_read,
   output var  logic [31:0] rdata,
   // bus side
   output var  logic [31:0] haddr,
   output var  logic [1:0]  htrans,
   output var  logic        hwrite,
   output var  logic [2:0]  hsize,
   output var  logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   logic [1:0] phase_reg;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_reg <= 2'h0;
         htrans    <= 2'h0;
         haddr     <= 32'h0;
         hwrite    <= 1'b0;
         hsize     <= 3'h2;
         hwdata    <= 32'h0;
         done      <= 1'b0;
         done_read <= 1'b0;
         rdata     <= 32'h0;
      end else begin
         done <= 1'b0;
         case (phase_reg)
            2'h0: if (req) begin
               haddr     <= req_addr;
               hwrite    <= req_write;
               htrans    <= 2'h2;
               phase_reg <= 2'h1;
            end
            2'h1: if (hready) begin
               htrans    <= 2'h0;
               hwdata    <= hwrite ? req_wdata : ~hwdata;
               phase_reg <= 2'h2;
            end
            default: if (hready) begin
               rdata     <= hrdata;
               done      <= 1'b1;
               done_read <= !hwrite;
               // released data lines show no stale value
               hwdata    <= ~hwdata;
               phase_reg <= 2'h0;
            end
         endcase
      end
   end
endmodule : ptc_ahb_master
`default_nettype wire

/* File: sim/tb_top.sv */
/*
 * Self-checking bench of the test control and error counter bank.
 * Assumes the bus model in ptc_ahb_master and one wait state per transfer.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ptc_defines.svh"

module tb_top;
   import ptc_pkg::*;

   logic        hclk;
   logic        hresetn;
   logic        req;
   logic        req_write;
   logic [31:0] req_addr;
   logic [31:0] req_wdata;
   logic        done;
   logic        done_read;
   logic [31:0] rdata;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [4:0]  ev;
   logic        repeater_mode;
   logic        raw_detect;
   logic        eq_probe;
   logic [2:0]  tenbt;
   logic [2:0]  led_norm;
   wire  logic [2:0]  leds;
   wire  logic [2:0]  synth;
   wire  logic [15:0] ctrl_seen;
   logic [31:0] exp_q[$];
   int          num_errors = 0;
   int          compares = 0;
   int          n_shift = 0;
   int          n_load = 0;

   assign ctrl_seen[10] = 1'b0;
   assign ctrl_seen[6]  = 1'b0;

   ptc_ahb_master agent (.hclk(hclk), .hresetn(hresetn), .req(req), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .done(done), .done_read(done_read),
      .rdata(rdata), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

   ptc_top #(.PHY_ADDR(`PTC_PHY_ADDR_RST)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .ev_false_carrier(ev[0]), .ev_disconnect(ev[1]),
      .ev_error_frame(ev[2]), .ev_symbol_error(ev[3]), .ev_early_eof(ev[4]),
      .repeater_mode(repeater_mode), .signal_detect_raw(raw_detect),
      .eq_probe_in(eq_probe), .tenbt_dig_in(tenbt), .led_speed_norm(led_norm[0]),
      .led_link_norm(led_norm[1]), .led_act_norm(led_norm[2]),
      .scrambler_bypass(ctrl_seen[15]), .encoder_bypass(ctrl_seen[14]),
      .force_h_pattern(ctrl_seen[13]), .force_34_pattern(ctrl_seen[12]),
      .adaptive_signal_detect(ctrl_seen[11]), .mdi_oe_n(ctrl_seen[9]),
      .dyn_pwrdn_disable(ctrl_seen[8]), .an_loopback(ctrl_seen[7]),
      .rx_filter_bypass(ctrl_seen[5]), .auto_polarity_disable(ctrl_seen[4]),
      .squelch_test_disable(ctrl_seen[3]), .ext_squelch(ctrl_seen[2]),
      .link_integrity_disable(ctrl_seen[1]), .jabber_disable(ctrl_seen[0]),
      .synth_shift_pulse(synth[0]), .synth_load_pulse(synth[1]),
      .break_down_timer_en(synth[2]), .led_speed(leds[0]), .led_link(leds[1]),
      .led_act(leds[2]));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] expected);
      compares++;
      if (seen !== expected) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
      end
   endtask : check

   task automatic report_and_stop();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop

   // one transfer; entered and left at a rising edge
   task automatic bus(input logic w, input ptc_idx_t idx, input logic [31:0] d);
      int k;
      req       <= 1'b1;
      req_write <= w;
      req_addr  <= {22'h0, idx, 2'b00};
      req_wdata <= d;
      @(posedge hclk);
      req <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 20) begin
         @(posedge hclk);
         k++;
      end
      if (k == 20) num_errors++;
   endtask : bus

   task automatic rd(input ptc_idx_t idx, input logic [31:0] expected);
      exp_q.push_back(expected);
      bus(1'b0, idx, 32'h0);
   endtask : rd

   task automatic pulse(input int k, input int n);
      repeat (n) begin
         ev[k] <= 1'b1;
         @(posedge hclk);
         ev[k] <= 1'b0;
         @(posedge hclk);
      end
   endtask : pulse

   // read results against the oldest note
   always @(posedge hclk) begin
      if (done === 1'b1 && done_read === 1'b1) begin
         if (exp_q.size() == 0) num_errors++;
         else check(rdata, exp_q.pop_front());
      end
   end

   always @(posedge hclk) begin
      if (synth[0] === 1'b1) n_shift++;
      if (synth[1] === 1'b1) n_load++;
   end

   // the saturation fill dominates the run time
   initial begin
      repeat (80000) @(posedge hclk);
      num_errors++;
      report_and_stop();
   end

   initial begin
      logic [31:0] v;
      int n;
      hresetn = 1'b0;
      req = 1'b0;
      req_write = 1'b0;
      req_addr = 32'h0;
      req_wdata = 32'h0;
      ev = 5'h0;
      repeater_mode = 1'b0;
      raw_detect = 1'b0;
      eq_probe = 1'b0;
      tenbt = 3'h0;
      led_norm = 3'h0;
      void'($urandom(32'h0e91676b));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(`PTC_IDX_CTRL, 32'h0);
      rd(`PTC_IDX_TEST, {27'h0, `PTC_PHY_ADDR_RST});
      bus(1'b1, `PTC_IDX_TEST, 32'h0000001e);
      rd(`PTC_IDX_TEST, {27'h0, `PTC_PHY_ADDR_RST});
      bus(1'b1, `PTC_IDX_FC, 32'h0000ffff);
      rd(`PTC_IDX_FC, 32'h0);
      rd(8'h10, 32'h0);
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 32'h0000ffff : (i == 1) ? 32'h0 : $urandom;
         raw_detect <= 1'($urandom_range(1, 0));
         bus(1'b1, `PTC_IDX_CTRL, v);
         rd(`PTC_IDX_CTRL, {16'h0, v[15:0] & `PTC_CTRL_WMASK});
         v = {16'h0, (v[15:0] & `PTC_CTRL_WMASK) | {4'h0, raw_detect, 11'h0}};
         check({16'h0, ctrl_seen}, v);
      end
      bus(1'b1, `PTC_IDX_TEST, 32'h00008000);
      bus(1'b1, `PTC_IDX_TEST, 32'h00004000);
      bus(1'b1, `PTC_IDX_TEST, 32'h0000f800);
      check(32'(n_shift), 32'h1);
      check(32'(n_load), 32'h1);
      check({31'h0, synth[2]}, 32'h1);
      rd(`PTC_IDX_TEST, {16'h0, 2'h0, 3'h7, 6'h0, `PTC_PHY_ADDR_RST});
      bus(1'b1, `PTC_IDX_TEST, 32'h00001000);
      for (int i = 0; i < 2; i++) begin
         eq_probe <= i[0];
         repeat (2) @(posedge hclk);
         check({31'h0, leds[0]}, {31'h0, eq_probe});
      end
      bus(1'b1, `PTC_IDX_TEST, 32'h00000800);
      tenbt <= 3'($urandom);
      repeat (2) @(posedge hclk);
      check({29'h0, leds}, {29'h0, tenbt});
      bus(1'b1, `PTC_IDX_TEST, 32'h0);
      led_norm <= 3'($urandom);
      repeat (2) @(posedge hclk);
      check({29'h0, leds}, {29'h0, led_norm});
      pulse(1, 3);
      rd(`PTC_IDX_DISC, 32'h0);
      repeater_mode <= 1'b1;
      for (int k = 0; k < 5; k++) begin
         n = $urandom_range(12, 1);
         pulse(k, n);
         rd(ptc_idx_t'(`PTC_IDX_FC + k), 32'(n));
         rd(ptc_idx_t'(`PTC_IDX_FC + k), 32'h0);
      end
      // fill past full scale, read under a steady event stream
      ev[3] <= 1'b1;
      repeat (65540) @(posedge hclk);
      rd(`PTC_IDX_SYM, 32'h0000ffff);
      rd(`PTC_IDX_SYM, 32'h5);
      ev[3] <= 1'b0;
      rd(`PTC_IDX_SYM, 32'h3);
      check({31'h0, hresp}, 32'h0);
      repeat (3) @(posedge hclk);
      check(32'(exp_q.size()), 32'h0);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
